// [uis_regs.svh]
// Register offsets, field positions, reset values and timing counts of the UART.
// Assumes byte addresses on an 8-bit register port with 32-bit data words.
//
// Overview of operation
// - Sixteen-entry transmit and receive byte FIFOs
// - Five to eight data bits, odd/even parity
// - One, one and half, two stop bits
// - Start, data LSB first, parity, stop bits
// - Baud equals clock over sixteen times divisor
// - Each bit lasts sixteen baud ticks
// - Receiver samples mid-bit, then every sixteen ticks
// - Divisor built from high and low bytes
// - Break generated on transmit, detected on receive
// - Request-to-send and clear-to-send flow control
// - DMA requests for both FIFOs
// - Baud clock reference output, always driven, low for one cycle per tick
// - Infrared: eight bits, no parity, one stop
// - Modem control bit six selects infrared pins
// - Infrared zero is three-sixteenths pulse, one none
// - Infrared input low means logic zero
// - Low-power infrared catches narrow pulses via divisor
// - Serial logic synchronised to bus clock
// - Config settles within eight cycles before transfers
// - Ident reports errors, timeout, data, empty by priority
`ifndef UIS_REGS_SVH
`define UIS_REGS_SVH
`define UIS_ADDR_DATA 8'h00
`define UIS_ADDR_IER 8'h04
`define UIS_ADDR_IDENT 8'h08
`define UIS_ADDR_LFC 8'h0C
`define UIS_ADDR_MCS 8'h10
`define UIS_ADDR_LSR 8'h14
`define UIS_ADDR_DIVL 8'h18
`define UIS_ADDR_DIVH 8'h1C
`define UIS_ADDR_DIVF 8'h20
`define UIS_ADDR_LPDIV 8'h24
`define UIS_ADDR_MSR 8'h28
`define UIS_ADDR_DMA 8'h2C
`define UIS_LFC_PAR_EN 3
`define UIS_LFC_EVEN 4
`define UIS_LFC_STOP2 2
`define UIS_LFC_BREAK 6
`define UIS_MCS_RTS 1
`define UIS_MCS_AUTOFLOW 5
`define UIS_MCS_IR 6
`define UIS_MCS_LOWPOWER 7
`define UIS_LFC_RESET 8'h03
`define UIS_ID_NONE 4'h1
`define UIS_ID_LINE 4'h6
`define UIS_ID_RXDATA 4'h4
`define UIS_ID_TIMEOUT 4'hC
`define UIS_ID_TX_HOLDING_EMPTY 4'h2
`define UIS_TICKS_PER_BIT 6'd16
`define UIS_MID_TICK 4'd7
`define UIS_IR_PULSE_TICKS 6'd3
`define UIS_STOP_1_5_TICKS 6'd24
`define UIS_STOP_2_TICKS 6'd32
`define UIS_SETTLE_CYCLES 4'd8
`define UIS_TIMEOUT_TICKS 10'd640
`endif

// [uis_pkg.sv]
// Types shared by the UART design.
// Assumes uis_regs.svh supplies every numeric constant.
package uis_pkg;
   typedef enum logic [2:0] {UIS_IDLE, UIS_START, UIS_DATA, UIS_PARITY, UIS_STOP} uis_state_t;
   typedef logic [7:0] uis_byte_t;
endpackage : uis_pkg

// [uis_uart.sv]
// UART with infrared pulse mode, FIFOs, flow control and DMA requests.
// Assumes one clock mclk for bus and serial logic, and synchronous serial inputs.
`timescale 1ns/100ps
`include "uis_regs.svh"
module uis_uart #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic ser_tx_out,
   input wire logic ser_rx_in,
   output logic ir_tx_out,
   input wire logic ir_rx_in,
   output logic rts_out_n,
   input wire logic cts_in_n,
   output logic baud_out_n,
   output logic dma_tx_req,
   output logic dma_rx_req
);
   import uis_pkg::*;
   localparam int AW = $clog2(FIFO_DEPTH);

   if (FIFO_DEPTH < 4 || (1 << AW) != FIFO_DEPTH) begin : g_chk
      $error("FIFO_DEPTH must be a power of two, at least 4");
   end

   // Character length minus one, shared by both shifters
   function automatic logic [2:0] last_bit(input logic ir, input logic [1:0] len);
      last_bit = ir ? 3'd7 : {1'b1, len};
   endfunction : last_bit

   logic [7:0] lfc_reg, mcs_reg, div_lo_reg, div_hi_reg;
   logic [3:0] div_frac_reg;
   logic [15:0] lp_div_reg;
   logic [2:0] ier_reg;
   logic [1:0] dma_ctl_reg;
   logic [3:0] settle_reg;
   logic oe_reg, pe_reg, fe_reg, bi_reg;
   logic [31:0] rdata_reg;

   uis_byte_t tx_mem [FIFO_DEPTH];
   uis_byte_t rx_mem [FIFO_DEPTH];
   logic [AW:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
   logic [AW:0] rx_level;
   logic tx_empty, tx_full, rx_empty, rx_full;
   logic tx_push, tx_pop, rx_push, rx_pop;

   logic [15:0] baud_cnt_reg, lp_cnt_reg;
   logic [3:0] frac_acc_reg;
   logic [4:0] frac_sum;
   logic [15:0] divisor;
   logic tick, lp_tick;

   uis_state_t tx_state_reg, rx_state_reg;
   logic [5:0] tx_cnt_reg;
   logic [3:0] rx_cnt_reg;
   logic [2:0] tx_idx_reg, rx_idx_reg;
   uis_byte_t tx_shift_reg, rx_shift_reg;
   logic tx_par_reg, rx_par_reg, tx_bit, tx_line;
   logic ir_mode, par_en, even, cfg_busy;
   logic [2:0] lastb;
   logic [5:0] stop_ticks;
   logic ir_seen_reg, rx_line_reg, rx_line, rx_sample;
   logic set_pe, set_fe, set_bi, set_oe, clr_lsr;
   logic [9:0] to_cnt_reg;
   logic timeout;
   logic [3:0] ident;
   logic ser_tx_reg, ir_tx_reg, rts_n_reg, baud_n_reg;

   assign ir_mode = mcs_reg[`UIS_MCS_IR];
   assign par_en = !ir_mode && lfc_reg[`UIS_LFC_PAR_EN];
   assign even = lfc_reg[`UIS_LFC_EVEN];
   assign lastb = last_bit(ir_mode, lfc_reg[1:0]);
   assign cfg_busy = settle_reg != 4'h0;

   // Register writes; a format change restarts the shifters
   always_ff @(posedge mclk) begin
      if (srst) begin
         lfc_reg <= `UIS_LFC_RESET;
         mcs_reg <= 8'h00;
         div_lo_reg <= 8'h00;
         div_hi_reg <= 8'h00;
         div_frac_reg <= 4'h0;
         lp_div_reg <= 16'h0000;
         ier_reg <= 3'h0;
         dma_ctl_reg <= 2'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `UIS_ADDR_IER: ier_reg <= reg_wdata[2:0];
            `UIS_ADDR_LFC: lfc_reg <= reg_wdata[7:0];
            `UIS_ADDR_MCS: mcs_reg <= reg_wdata[7:0];
            `UIS_ADDR_DIVL: div_lo_reg <= reg_wdata[7:0];
            `UIS_ADDR_DIVH: div_hi_reg <= reg_wdata[7:0];
            `UIS_ADDR_DIVF: div_frac_reg <= reg_wdata[3:0];
            `UIS_ADDR_LPDIV: lp_div_reg <= reg_wdata[15:0];
            `UIS_ADDR_DMA: dma_ctl_reg <= reg_wdata[1:0];
            default: ;
         endcase
      end
   end

   // Shifters held idle while new settings take effect
   always_ff @(posedge mclk) begin
      if (srst) begin
         settle_reg <= `UIS_SETTLE_CYCLES;
      end else if (reg_wr && (reg_addr == `UIS_ADDR_LFC || reg_addr == `UIS_ADDR_MCS ||
                              reg_addr == `UIS_ADDR_DIVL || reg_addr == `UIS_ADDR_DIVH ||
                              reg_addr == `UIS_ADDR_DIVF || reg_addr == `UIS_ADDR_LPDIV)) begin
         settle_reg <= `UIS_SETTLE_CYCLES;
      end else if (cfg_busy) begin
         settle_reg <= settle_reg - 4'h1;
      end
   end

   // FIFOs
   assign tx_empty = tx_wp_reg == tx_rp_reg;
   assign tx_full = tx_wp_reg == {~tx_rp_reg[AW], tx_rp_reg[AW-1:0]};
   assign rx_empty = rx_wp_reg == rx_rp_reg;
   assign rx_full = rx_wp_reg == {~rx_rp_reg[AW], rx_rp_reg[AW-1:0]};
   assign rx_level = rx_wp_reg - rx_rp_reg;
   assign tx_push = reg_wr && reg_addr == `UIS_ADDR_DATA && !tx_full;
   assign rx_pop = reg_rd && reg_addr == `UIS_ADDR_DATA && !rx_empty;

   always_ff @(posedge mclk) begin
      if (srst) begin
         tx_wp_reg <= '0;
         tx_rp_reg <= '0;
      end else begin
         if (tx_push) begin
            tx_mem[tx_wp_reg[AW-1:0]] <= reg_wdata[7:0];
            tx_wp_reg <= tx_wp_reg + 1'b1;
         end
         if (tx_pop) begin
            tx_rp_reg <= tx_rp_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_wp_reg <= '0;
         rx_rp_reg <= '0;
      end else begin
         if (rx_push && !rx_full) begin
            rx_mem[rx_wp_reg[AW-1:0]] <= rx_shift_reg >> (3'd7 - lastb);
            rx_wp_reg <= rx_wp_reg + 1'b1;
         end
         if (rx_pop) begin
            rx_rp_reg <= rx_rp_reg + 1'b1;
         end
      end
   end

   // Baud tick: integer divisor plus a sixteenths fraction that adds a cycle on carry
   assign divisor = {div_hi_reg, div_lo_reg};
   assign frac_sum = {1'b0, frac_acc_reg} + {1'b0, div_frac_reg};
   assign tick = baud_cnt_reg == 16'h0000 && divisor != 16'h0000 && !cfg_busy;

   always_ff @(posedge mclk) begin
      if (srst || cfg_busy || divisor == 16'h0000) begin
         baud_cnt_reg <= 16'h0000;
         frac_acc_reg <= 4'h0;
      end else if (baud_cnt_reg == 16'h0000) begin
         baud_cnt_reg <= divisor - 16'h0001 + {15'h0000, frac_sum[4]};
         frac_acc_reg <= frac_sum[3:0];
      end else begin
         baud_cnt_reg <= baud_cnt_reg - 16'h0001;
      end
   end

   // Low-power strobe samples the infrared input every lp_div_reg cycles instead of on the baud tick
   assign lp_tick = lp_cnt_reg == 16'h0000 && lp_div_reg != 16'h0000;

   always_ff @(posedge mclk) begin
      if (srst || lp_cnt_reg == 16'h0000) begin
         lp_cnt_reg <= srst ? 16'h0000 : lp_div_reg - (lp_div_reg != 16'h0000 ? 16'h0001 : 16'h0000);
      end else begin
         lp_cnt_reg <= lp_cnt_reg - 16'h0001;
      end
   end

   // Transmitter
   assign stop_ticks = (ir_mode || !lfc_reg[`UIS_LFC_STOP2]) ? `UIS_TICKS_PER_BIT :
                       (lastb == 3'd4) ? `UIS_STOP_1_5_TICKS : `UIS_STOP_2_TICKS;
   assign tx_pop = tick && tx_state_reg == UIS_IDLE && !tx_empty &&
                   !(mcs_reg[`UIS_MCS_AUTOFLOW] && cts_in_n);

   always_comb begin
      case (tx_state_reg)
         UIS_START: tx_bit = 1'b0;
         UIS_DATA: tx_bit = tx_shift_reg[0];
         UIS_PARITY: tx_bit = even ? tx_par_reg : ~tx_par_reg;
         default: tx_bit = 1'b1;
      endcase
   end
   assign tx_line = tx_bit && !(lfc_reg[`UIS_LFC_BREAK] && !ir_mode);

   always_ff @(posedge mclk) begin
      if (srst || cfg_busy) begin
         tx_state_reg <= UIS_IDLE;
         tx_cnt_reg <= 6'd0;
         tx_idx_reg <= 3'd0;
         tx_shift_reg <= 8'h00;
         tx_par_reg <= 1'b0;
      end else if (tick) begin
         tx_cnt_reg <= tx_cnt_reg + 6'd1;
         case (tx_state_reg)
            UIS_IDLE: begin
               tx_cnt_reg <= 6'd0;
               if (tx_pop) begin
                  tx_shift_reg <= tx_mem[tx_rp_reg[AW-1:0]];
                  tx_par_reg <= 1'b0;
                  tx_state_reg <= UIS_START;
               end
            end
            UIS_START: begin
               if (tx_cnt_reg == `UIS_TICKS_PER_BIT - 6'd1) begin
                  tx_cnt_reg <= 6'd0;
                  tx_idx_reg <= 3'd0;
                  tx_state_reg <= UIS_DATA;
               end
            end
            UIS_DATA: begin
               if (tx_cnt_reg == `UIS_TICKS_PER_BIT - 6'd1) begin
                  tx_cnt_reg <= 6'd0;
                  tx_shift_reg <= tx_shift_reg >> 1;
                  tx_par_reg <= tx_par_reg ^ tx_shift_reg[0];
                  tx_idx_reg <= tx_idx_reg + 3'd1;
                  if (tx_idx_reg == lastb) begin
                     tx_state_reg <= par_en ? UIS_PARITY : UIS_STOP;
                  end
               end
            end
            UIS_PARITY: begin
               if (tx_cnt_reg == `UIS_TICKS_PER_BIT - 6'd1) begin
                  tx_cnt_reg <= 6'd0;
                  tx_state_reg <= UIS_STOP;
               end
            end
            UIS_STOP: begin
               if (tx_cnt_reg == stop_ticks - 6'd1) begin
                  tx_cnt_reg <= 6'd0;
                  tx_state_reg <= UIS_IDLE;
               end
            end
            default: tx_state_reg <= UIS_IDLE;
         endcase
      end
   end

   // Pin drivers; the infrared pulse covers the first three ticks of a zero bit
   always_ff @(posedge mclk) begin
      if (srst) begin
         ser_tx_reg <= 1'b1;
         ir_tx_reg <= 1'b0;
         baud_n_reg <= 1'b1;
         rts_n_reg <= 1'b1;
      end else begin
         ser_tx_reg <= ir_mode ? 1'b1 : tx_line;
         ir_tx_reg <= ir_mode && !tx_bit && tx_cnt_reg < `UIS_IR_PULSE_TICKS;
         baud_n_reg <= !tick;
         // Auto mode drops the request two entries before the FIFO fills
         rts_n_reg <= !(mcs_reg[`UIS_MCS_RTS] && !(mcs_reg[`UIS_MCS_AUTOFLOW] &&
                      rx_level >= (AW + 1)'(FIFO_DEPTH - 2)));
      end
   end

   // Receive line: an infrared low seen on a tick or low-power strobe is held until the next sample
   assign rx_sample = tick && ((rx_state_reg == UIS_START && rx_cnt_reg == `UIS_MID_TICK) ||
                      (rx_state_reg != UIS_IDLE && rx_state_reg != UIS_START &&
                       rx_cnt_reg == 4'hF));
   assign rx_line = ir_mode ? !ir_seen_reg : rx_line_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         ir_seen_reg <= 1'b0;
         rx_line_reg <= 1'b1;
      end else begin
         rx_line_reg <= ser_rx_in;
         if ((mcs_reg[`UIS_MCS_LOWPOWER] ? lp_tick : tick) && !ir_rx_in) begin
            ir_seen_reg <= 1'b1;
         end else if (rx_sample || !ir_mode) begin
            ir_seen_reg <= 1'b0;
         end
      end
   end

   // Receiver
   always_ff @(posedge mclk) begin
      if (srst || cfg_busy) begin
         rx_state_reg <= UIS_IDLE;
         rx_cnt_reg <= 4'h0;
         rx_idx_reg <= 3'd0;
         rx_shift_reg <= 8'h00;
         rx_par_reg <= 1'b0;
         rx_push <= 1'b0;
         set_pe <= 1'b0;
         set_fe <= 1'b0;
         set_bi <= 1'b0;
      end else begin
         rx_push <= 1'b0;
         set_pe <= 1'b0;
         set_fe <= 1'b0;
         set_bi <= 1'b0;
         if (tick) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            case (rx_state_reg)
               UIS_IDLE: begin
                  rx_cnt_reg <= 4'h0;
                  if (!rx_line) begin
                     rx_state_reg <= UIS_START;
                  end
               end
               UIS_START: begin
                  if (rx_cnt_reg == `UIS_MID_TICK) begin
                     rx_cnt_reg <= 4'h0;
                     rx_idx_reg <= 3'd0;
                     rx_par_reg <= 1'b0;
                     rx_state_reg <= rx_line ? UIS_IDLE : UIS_DATA;
                  end
               end
               UIS_DATA: begin
                  if (rx_cnt_reg == 4'hF) begin
                     rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                     rx_par_reg <= rx_par_reg ^ rx_line;
                     rx_idx_reg <= rx_idx_reg + 3'd1;
                     if (rx_idx_reg == lastb) begin
                        rx_state_reg <= par_en ? UIS_PARITY : UIS_STOP;
                     end
                  end
               end
               UIS_PARITY: begin
                  if (rx_cnt_reg == 4'hF) begin
                     set_pe <= (rx_par_reg ^ rx_line) == even;
                     rx_par_reg <= rx_line;
                     rx_state_reg <= UIS_STOP;
                  end
               end
               UIS_STOP: begin
                  if (rx_cnt_reg == 4'hF) begin
                     set_fe <= !rx_line;
                     set_bi <= !rx_line && rx_shift_reg == 8'h00 &&
                               !(par_en && rx_par_reg);
                     rx_push <= 1'b1;
                     rx_state_reg <= UIS_IDLE;
                  end
               end
               default: rx_state_reg <= UIS_IDLE;
            endcase
         end
      end
   end

   // Line status flags: sticky, cleared by reading, a new event outranks the clear
   assign set_oe = rx_push && rx_full;
   assign clr_lsr = reg_rd && reg_addr == `UIS_ADDR_LSR;

   always_ff @(posedge mclk) begin
      if (srst) begin
         oe_reg <= 1'b0;
         pe_reg <= 1'b0;
         fe_reg <= 1'b0;
         bi_reg <= 1'b0;
      end else begin
         oe_reg <= set_oe || (oe_reg && !clr_lsr);
         pe_reg <= set_pe || (pe_reg && !clr_lsr);
         fe_reg <= set_fe || (fe_reg && !clr_lsr);
         bi_reg <= set_bi || (bi_reg && !clr_lsr);
      end
   end

   // Character timeout: four character times of silence with data waiting
   always_ff @(posedge mclk) begin
      if (srst || rx_empty || rx_push || rx_pop) begin
         to_cnt_reg <= 10'd0;
      end else if (tick && to_cnt_reg != `UIS_TIMEOUT_TICKS) begin
         to_cnt_reg <= to_cnt_reg + 10'd1;
      end
   end
   assign timeout = to_cnt_reg == `UIS_TIMEOUT_TICKS;

   always_comb begin
      if (ier_reg[2] && (oe_reg || pe_reg || fe_reg || bi_reg)) begin
         ident = `UIS_ID_LINE;
      end else if (ier_reg[0] && !rx_empty && !timeout) begin
         ident = `UIS_ID_RXDATA;
      end else if (ier_reg[0] && timeout) begin
         ident = `UIS_ID_TIMEOUT;
      end else if (ier_reg[1] && tx_empty) begin
         ident = `UIS_ID_TX_HOLDING_EMPTY;
      end else begin
         ident = `UIS_ID_NONE;
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge mclk) begin
      if (srst || !reg_rd) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         case (reg_addr)
            `UIS_ADDR_DATA: rdata_reg <= {24'h00_0000, rx_mem[rx_rp_reg[AW-1:0]]};
            `UIS_ADDR_IER: rdata_reg <= {29'h0000_0000, ier_reg};
            `UIS_ADDR_IDENT: rdata_reg <= {28'h000_0000, ident};
            `UIS_ADDR_LFC: rdata_reg <= {24'h00_0000, lfc_reg};
            `UIS_ADDR_MCS: rdata_reg <= {24'h00_0000, mcs_reg};
            `UIS_ADDR_LSR: rdata_reg <= {25'h000_0000, tx_empty && tx_state_reg == UIS_IDLE,
                                         tx_empty, bi_reg, fe_reg, pe_reg, oe_reg, !rx_empty};
            `UIS_ADDR_DIVL: rdata_reg <= {24'h00_0000, div_lo_reg};
            `UIS_ADDR_DIVH: rdata_reg <= {24'h00_0000, div_hi_reg};
            `UIS_ADDR_DIVF: rdata_reg <= {28'h000_0000, div_frac_reg};
            `UIS_ADDR_LPDIV: rdata_reg <= {16'h0000, lp_div_reg};
            `UIS_ADDR_MSR: rdata_reg <= {31'h0000_0000, !cts_in_n};
            `UIS_ADDR_DMA: rdata_reg <= {30'h0000_0000, dma_ctl_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign reg_rdata = rdata_reg;
   assign ser_tx_out = ser_tx_reg;
   assign ir_tx_out = ir_tx_reg;
   assign baud_out_n = baud_n_reg;
   assign rts_out_n = rts_n_reg;
   assign dma_tx_req = dma_ctl_reg[0] && !tx_full;
   assign dma_rx_req = dma_ctl_reg[1] && !rx_empty;

endmodule : uis_uart

// [uis_uart_assertions.sv]
// Port-level checks of the UART, bound into uis_uart.
// Assumes one clock mclk and synchronous active-high srst.
`timescale 1ns/100ps
module uis_uart_checker #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic ser_tx_out,
   input wire logic ir_tx_out,
   input wire logic rts_out_n,
   input wire logic baud_out_n,
   input wire logic dma_tx_req,
   input wire logic dma_rx_req
);
   logic [7:0] lo_ticks;
   logic [3:0] ir_ticks;
   // Any window of k bit times holds 16k ticks, whatever the tick phase
   always_ff @(posedge mclk) begin
      if (srst || ser_tx_out) lo_ticks <= 8'h00;
      else if (!baud_out_n) lo_ticks <= lo_ticks + 8'h01;
   end
   always_ff @(posedge mclk) begin
      if (srst || !ir_tx_out) ir_ticks <= 4'h0;
      else if (!baud_out_n) ir_ticks <= ir_ticks + 4'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_quiet; (ser_tx_out && !ir_tx_out)[*8]; endsequence
   sequence s_ir_rest; (!ir_tx_out)[*8]; endsequence
   property p_settle; $fell(srst) |-> s_quiet; endproperty
   a_settle: assert property (p_settle) else $error("line moved while settling");
   property p_rst_vals; $fell(srst) |-> rts_out_n && baud_out_n && !dma_tx_req && !dma_rx_req;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("outputs not idle");
   property p_rdata_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
   // The line register follows the tick by one cycle
   property p_bit_edge; $changed(ser_tx_out) |-> !$past(baud_out_n); endproperty
   a_bit_edge: assert property (p_bit_edge) else $error("line moved off a tick");
   property p_bit_len; $rose(ser_tx_out) |-> lo_ticks[3:0] == 4'h0 && lo_ticks != 8'h00;
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("low run not whole bits");
   property p_ir_ser; ir_tx_out |-> ser_tx_out; endproperty
   a_ir_ser: assert property (p_ir_ser) else $error("serial line used in infrared");
   property p_ir_pulse; $fell(ir_tx_out) |-> ir_ticks == 4'h3; endproperty
   a_ir_pulse: assert property (p_ir_pulse) else $error("infrared pulse width");
   property p_ir_gap; $fell(ir_tx_out) |-> s_ir_rest; endproperty
   a_ir_gap: assert property (p_ir_gap) else $error("infrared pulse too close");
endmodule : uis_uart_checker
bind uis_uart uis_uart_checker #(.FIFO_DEPTH(FIFO_DEPTH)) uis_uart_checker_i (.mclk(mclk),
   .srst(srst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ser_tx_out(ser_tx_out),
   .ir_tx_out(ir_tx_out), .rts_out_n(rts_out_n), .baud_out_n(baud_out_n),
   .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));

// [uis_peer.sv]
// Behavioural serial peer: decodes frames from the UART and sends frames to it.
// Assumes the bench sets nbits and the parity fields before each frame; bit_cyc keeps its 64.
`timescale 1ns/100ps
module uis_peer (
   input wire logic mclk,
   input wire logic tx_line,
   output logic rx_line,
   output logic ir_line
);
   import uis_pkg::*;
   int bit_cyc = 64;
   int nbits = 8;
   int bad = 0;
   logic par_en = 1'b0;
   logic par_even = 1'b0;
   uis_byte_t got_q[$];
   initial begin
      rx_line = 1'b1;
      ir_line = 1'b1;
   end
   // Mid-bit sampling tolerates a tick of phase between the two ends
   always begin : rx_side
      uis_byte_t b;
      @(negedge tx_line);
      repeat (bit_cyc / 2) @(posedge mclk);
      b = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         repeat (bit_cyc) @(posedge mclk);
         b[i] = tx_line;
      end
      if (par_en) begin
         repeat (bit_cyc) @(posedge mclk);
         if ((^b ^ tx_line) === par_even) bad++;
      end
      repeat (bit_cyc) @(posedge mclk);
      if (tx_line !== 1'b1) bad++;
      got_q.push_back(b);
   end
   task automatic send(input uis_byte_t b, input logic ir, input logic bad_par);
      logic [11:0] f;
      logic p;
      int n;
      f = 12'hFFE;
      p = !par_even ^ bad_par;
      for (int i = 0; i < nbits; i++) begin
         f[i + 1] = b[i];
         p = p ^ b[i];
      end
      n = nbits + 1;
      if (par_en) f[n++] = p;
      f[n++] = 1'b1;
      for (int k = 0; k < n; k++) begin
         @(posedge mclk);
         if (ir) ir_line <= f[k];
         else rx_line <= f[k];
         repeat (ir ? bit_cyc * 3 / 16 : bit_cyc - 1) @(posedge mclk);
         ir_line <= 1'b1;
         if (ir) repeat (bit_cyc * 13 / 16 - 1) @(posedge mclk);
      end
   endtask : send
endmodule : uis_peer

// [uis_uart_tb_top.sv]
// Self-checking bench for uis_uart: formats, FIFO limit, flow control, DMA, infrared.
// Assumes uis_peer on the serial pins and the bound checker; divisor 4 gives 64-cycle bits.
`timescale 1ns/100ps
`include "uis_regs.svh"
`define UIS_CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin miscompares++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module uis_uart_tb_top;
   import uis_pkg::*;
   logic mclk, srst, reg_wr, reg_rd, cts_in_n, ser_tx_out, ser_rx_in, ir_tx_out, ir_rx_in;
   logic rts_out_n, baud_out_n, dma_tx_req, dma_rx_req;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   int miscompares = 0;
   int total_checks = 0;
   int ir_pulses = 0;
   uis_uart #(.FIFO_DEPTH(16)) uis_uart_i (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ser_tx_out(ser_tx_out), .ser_rx_in(ser_rx_in), .ir_tx_out(ir_tx_out),
      .ir_rx_in(ir_rx_in), .rts_out_n(rts_out_n), .cts_in_n(cts_in_n),
      .baud_out_n(baud_out_n), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
   uis_peer uis_peer_i (.mclk(mclk), .tx_line(ser_tx_out), .rx_line(ser_rx_in),
      .ir_line(ir_rx_in));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge ir_tx_out) ir_pulses++;
   initial begin
      #500000;
      miscompares++;
      results();
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] mk, ex, input string nm);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 `UIS_CHK(nm, ex, reg_rdata & mk)
   endtask : chk_rd
   function automatic uis_byte_t trim(uis_byte_t b, int len);
      return b & 8'((9'h001 << len) - 9'h001);
   endfunction : trim
   function automatic int ir_zeros(uis_byte_t b);
      return 9 - $countones(b);
   endfunction : ir_zeros
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   initial begin
      uis_byte_t b, b2;
      logic [7:0] lfc;
      int len;
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      cts_in_n = 1'b0;
      len = $urandom(34);
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      chk_rd(`UIS_ADDR_LFC, 32'hFF, 32'h03, "format reset");
      chk_rd(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
      wr(`UIS_ADDR_DIVL, 32'h04);
      for (int k = 0; k < 8; k++) begin
         lfc = 8'($urandom) & 8'h1F;
         if (k < 4) lfc[1:0] = 2'(k);
         len = lfc[1:0] + 5;
         b = 8'($urandom);
         b2 = 8'($urandom);
         uis_peer_i.nbits = len;
         uis_peer_i.par_en = lfc[3];
         uis_peer_i.par_even = lfc[4];
         wr(`UIS_ADDR_LFC, 32'(lfc));
         repeat (8) @(posedge mclk);
         wr(`UIS_ADDR_DATA, 32'(b));
         uis_peer_i.send(b2, 1'b0, 1'b0);
         repeat (300) @(posedge mclk);
         `UIS_CHK("sent", trim(b, len), uis_peer_i.got_q.pop_front())
         chk_rd(`UIS_ADDR_LSR, 32'h01, 32'h01, "ready");
         chk_rd(`UIS_ADDR_DATA, 32'hFF, 32'(trim(b2, len)), "received");
      end
      uis_peer_i.nbits = 8;
      uis_peer_i.par_en = 1'b1;
      uis_peer_i.par_even = 1'b1;
      wr(`UIS_ADDR_LFC, 32'h1B);
      repeat (8) @(posedge mclk);
      uis_peer_i.send(8'hA5, 1'b0, 1'b1);
      repeat (40) @(posedge mclk);
      chk_rd(`UIS_ADDR_LSR, 32'h04, 32'h04, "parity flag");
      chk_rd(`UIS_ADDR_DATA, 32'hFF, 32'hA5, "flagged byte");
      uis_peer_i.par_en = 1'b0;
      wr(`UIS_ADDR_LFC, 32'h03);
      wr(`UIS_ADDR_MCS, 32'h22);
      cts_in_n <= 1'b1;
      wr(`UIS_ADDR_DMA, 32'h03);
      #1 `UIS_CHK("dma", 1'b1, dma_tx_req)
      for (int k = 0; k < 17; k++) wr(`UIS_ADDR_DATA, 32'(k * 37));
      #1 `UIS_CHK("dma full", 1'b0, dma_tx_req)
      repeat (700) @(posedge mclk);
      `UIS_CHK("held", 0, uis_peer_i.got_q.size())
      `UIS_CHK("rts", 1'b0, rts_out_n)
      cts_in_n <= 1'b0;
      repeat (16 * 680) @(posedge mclk);
      `UIS_CHK("count", 16, uis_peer_i.got_q.size())
      for (int k = 0; k < 16; k++) `UIS_CHK("order", 8'(k * 37), uis_peer_i.got_q.pop_front())
      wr(`UIS_ADDR_LFC, 32'h18);
      wr(`UIS_ADDR_MCS, 32'hC0);
      wr(`UIS_ADDR_LPDIV, 32'h02);
      repeat (8) @(posedge mclk);
      ir_pulses = 0;
      b = 8'($urandom);
      wr(`UIS_ADDR_DATA, 32'(b));
      repeat (800) @(posedge mclk);
      `UIS_CHK("ir pulses", ir_zeros(b), ir_pulses)
      uis_peer_i.send(b, 1'b1, 1'b0);
      repeat (40) @(posedge mclk);
      `UIS_CHK("dma rx", 1'b1, dma_rx_req)
      wr(`UIS_ADDR_IER, 32'h01);
      chk_rd(`UIS_ADDR_IDENT, 32'h0F, 32'h04, "ident");
      chk_rd(`UIS_ADDR_DATA, 32'hFF, 32'(b), "ir byte");
      `UIS_CHK("peer faults", 0, uis_peer_i.bad)
      results();
   end
endmodule : uis_uart_tb_top
